// file: eif_irq.sv
// Purpose: Flags, enables and priority routing for external lines one and two
//          and the first peripheral flag register
// Assumes: All inputs synchronous to core_clk; event inputs are one-cycle pulses
// Notes:
// Notes on behaviour
// - Flags set on their event whatever the enable or global bits hold.
// - Parallel port flag sets on a finished access, holds until written zero.
// - On the small package the parallel port flag is absent, reads zero.
// - Converter flag sets when a conversion ends, holds until cleared.
// - Receive flag is read-only, follows the full receive buffer.
// - Transmit flag is read-only, follows the empty transmit buffer.
// - Sync serial flag sets when a transfer ends, holds until cleared.
// - In capture mode the capture/compare flag sets on a capture.
// - In compare mode the capture/compare flag sets on a match.
// - In pulse-width mode the unit does not drive its flag.
// - Timer-two flag sets when count equals period, holds until cleared.
// - Timer-one flag sets on overflow, holds until cleared.
// - Peripheral flags sit in a flag register, one bit per source.
// - Global bits gate requests per priority mode.
// - Without priorities, peripheral requests also need the peripheral enable.
// - Return from interrupt sets the global bit of the level in service.
// - Pin events reach the core three to four cycles after the edge.
`default_nettype none

module eif_irq (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire eif_pkg::eif_bus_req_t   bus_req,
  output logic [eif_pkg::DATA_W-1:0]   rd_data,
  input  wire logic                    small_package,
  input  wire logic                    ext_line_one,
  input  wire logic                    ext_line_two,
  input  wire eif_pkg::eif_periph_evt_t periph_evt,
  input  wire eif_pkg::eif_ccp_mode_t  capcomp_mode,
  input  wire logic [7:0]              timer_two_count,
  input  wire logic [7:0]              timer_two_period,
  input  wire logic                    vector_taken,
  input  wire logic                    vector_high,
  input  wire logic                    return_from_irq_instr,
  input  wire logic                    return_high,
  output logic                         irq_high,
  output logic                         irq_low
);

  logic [7:0] ext_line_irq_ctrl_ff;
  logic [7:0] periph_irq_flags_one_ff;
  logic [7:0] global_ctrl_ff;
  logic [7:0] periph_enable_ff;
  logic [7:0] periph_prio_ff;
  logic [7:0] rd_data_ff;
  logic       irq_high_ff;
  logic       irq_low_ff;
  logic       small_pkg_ff;
  logic       line_one_prev_ff;
  logic       line_two_prev_ff;
  logic [eif_pkg::EXT_PIPE_LEN-1:0] line_one_pipe_ff;
  logic [eif_pkg::EXT_PIPE_LEN-1:0] line_two_pipe_ff;

  logic       wr_ext;
  logic       wr_pir;
  logic       wr_glb;
  logic       wr_pie;
  logic       wr_pip;
  logic       line_one_edge;
  logic       line_two_edge;
  logic       line_one_set;
  logic       line_two_set;
  logic [7:0] pir_src;
  logic       capcomp_evt;
  logic       ext_one_req;
  logic       ext_two_req;
  logic [7:0] periph_req;
  logic       prio_on;
  logic       nxt_irq_high;
  logic       nxt_irq_low;
  logic [7:0] nxt_rd_data;

  assign wr_ext = bus_req.wr && (bus_req.addr == eif_pkg::OFS_EXT_CTRL);
  assign wr_pir = bus_req.wr && (bus_req.addr == eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE);
  assign wr_glb = bus_req.wr && (bus_req.addr == eif_pkg::OFS_GLOBAL);
  assign wr_pie = bus_req.wr && (bus_req.addr == eif_pkg::OFS_PIE);
  assign wr_pip = bus_req.wr && (bus_req.addr == eif_pkg::OFS_PIP);

  assign prio_on = global_ctrl_ff[eif_pkg::PRIORITY_LEVELS_ON_BIT];

  // Strap sampled every cycle like the pins; a change takes one cycle to act
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      small_pkg_ff <= 1'b0;
    end else begin
      small_pkg_ff <= small_package;
    end
  end

  // Pin edge detect and fixed delay line
  assign line_one_edge = ext_line_one && !line_one_prev_ff;
  assign line_two_edge = ext_line_two && !line_two_prev_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_one_prev_ff <= 1'b0;
      line_two_prev_ff <= 1'b0;
    end else begin
      line_one_prev_ff <= ext_line_one;
      line_two_prev_ff <= ext_line_two;
    end
  end

  // Fixed depth keeps latency identical whatever the core executes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_one_pipe_ff <= '0;
      line_two_pipe_ff <= '0;
    end else begin
      line_one_pipe_ff <= {line_one_pipe_ff[eif_pkg::EXT_PIPE_LEN-2:0], line_one_edge};
      line_two_pipe_ff <= {line_two_pipe_ff[eif_pkg::EXT_PIPE_LEN-2:0], line_two_edge};
    end
  end

  assign line_one_set = line_one_pipe_ff[eif_pkg::EXT_PIPE_LEN-1];
  assign line_two_set = line_two_pipe_ff[eif_pkg::EXT_PIPE_LEN-1];

  // Line control register; a new edge wins over a clearing write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_line_irq_ctrl_ff <= eif_pkg::EXT_CTRL_RST;
    end else begin
      if (wr_ext) begin
        ext_line_irq_ctrl_ff <= bus_req.wdata & eif_pkg::EXT_CTRL_WMASK;
      end
      if (line_one_set) begin
        ext_line_irq_ctrl_ff[eif_pkg::EXT_ONE_FLAG_BIT] <= 1'b1;
      end
      if (line_two_set) begin
        ext_line_irq_ctrl_ff[eif_pkg::EXT_TWO_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // Capture/compare event follows the unit mode; pulse-width leaves it alone
  always_comb begin
    case (capcomp_mode)
      eif_pkg::CCP_CAPTURE: capcomp_evt = periph_evt.capture_evt;
      eif_pkg::CCP_COMPARE: capcomp_evt = periph_evt.compare_evt;
      eif_pkg::CCP_PWM:     capcomp_evt = 1'b0;
      default:              capcomp_evt = 1'b0;
    endcase
  end

  // Set sources, one per flag bit
  always_comb begin
    pir_src = 8'h00;
    pir_src[eif_pkg::PSP_BIT]  = periph_evt.psp_access_done;
    pir_src[eif_pkg::ADC_BIT]  = periph_evt.conv_done;
    pir_src[eif_pkg::RX_BIT]   = periph_evt.rx_full;
    pir_src[eif_pkg::TX_BIT]   = periph_evt.tx_empty;
    pir_src[eif_pkg::SSP_BIT]  = periph_evt.ssp_xfer_done;
    pir_src[eif_pkg::CCP_BIT]  = capcomp_evt;
    pir_src[eif_pkg::TIMER_TWO_COUNT_BIT] = (timer_two_count == timer_two_period);
    pir_src[eif_pkg::TIMER_ONE_COUNT_BIT] = periph_evt.timer_one_overflow;
  end

  // One flag bit per source, kept apart from enables
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          periph_irq_flags_one_ff[gi] <= eif_pkg::PERIPH_IRQ_FLAGS_ONE_RST[gi];
        end else if ((gi == eif_pkg::PSP_BIT) && small_pkg_ff) begin
          periph_irq_flags_one_ff[gi] <= 1'b0;
        end else if (eif_pkg::PERIPH_IRQ_FLAGS_ONE_RO_MASK[gi]) begin
          // Mirrors the buffer state; software access to the buffer clears it
          periph_irq_flags_one_ff[gi] <= pir_src[gi];
        end else if (wr_pir) begin
          periph_irq_flags_one_ff[gi] <= bus_req.wdata[gi] | pir_src[gi];
        end else begin
          periph_irq_flags_one_ff[gi] <= periph_irq_flags_one_ff[gi] | pir_src[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      periph_enable_ff <= eif_pkg::PIE_RST;
      periph_prio_ff   <= eif_pkg::PIP_RST;
    end else begin
      if (wr_pie) begin
        periph_enable_ff <= bus_req.wdata;
      end
      if (wr_pip) begin
        periph_prio_ff <= bus_req.wdata;
      end
    end
  end

  // Global bits: vectoring clears the level taken, return restores it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      global_ctrl_ff <= eif_pkg::GLOBAL_RST;
    end else if (return_from_irq_instr) begin
      if (!prio_on || return_high) begin
        global_ctrl_ff[eif_pkg::GIE_BIT] <= 1'b1;
      end else begin
        global_ctrl_ff[eif_pkg::PERIPHERAL_IRQ_ENABLE_BIT] <= 1'b1;
      end
    end else if (vector_taken) begin
      if (!prio_on || vector_high) begin
        global_ctrl_ff[eif_pkg::GIE_BIT] <= 1'b0;
      end else begin
        global_ctrl_ff[eif_pkg::PERIPHERAL_IRQ_ENABLE_BIT] <= 1'b0;
      end
    end else if (wr_glb) begin
      global_ctrl_ff <= bus_req.wdata & eif_pkg::GLOBAL_WMASK;
    end
  end

  // Enabled requests
  assign ext_one_req = ext_line_irq_ctrl_ff[eif_pkg::EXT_ONE_FLAG_BIT]
                    && ext_line_irq_ctrl_ff[eif_pkg::EXT_ONE_EN_BIT];
  assign ext_two_req = ext_line_irq_ctrl_ff[eif_pkg::EXT_TWO_FLAG_BIT]
                    && ext_line_irq_ctrl_ff[eif_pkg::EXT_TWO_EN_BIT];
  assign periph_req  = periph_irq_flags_one_ff & periph_enable_ff;

  // Routing to the two core request lines
  always_comb begin
    nxt_irq_high = 1'b0;
    nxt_irq_low  = 1'b0;
    if (!prio_on) begin
      nxt_irq_high = global_ctrl_ff[eif_pkg::GIE_BIT] && (ext_one_req || ext_two_req
                  || (global_ctrl_ff[eif_pkg::PERIPHERAL_IRQ_ENABLE_BIT] && (|periph_req)));
    end else begin
      nxt_irq_high = global_ctrl_ff[eif_pkg::GIE_BIT] &&
        ((ext_one_req && ext_line_irq_ctrl_ff[eif_pkg::EXT_ONE_PRIO_BIT])
        || (ext_two_req && ext_line_irq_ctrl_ff[eif_pkg::EXT_TWO_PRIO_BIT])
        || (|(periph_req & periph_prio_ff)));
      nxt_irq_low = global_ctrl_ff[eif_pkg::PERIPHERAL_IRQ_ENABLE_BIT] &&
        ((ext_one_req && !ext_line_irq_ctrl_ff[eif_pkg::EXT_ONE_PRIO_BIT])
        || (ext_two_req && !ext_line_irq_ctrl_ff[eif_pkg::EXT_TWO_PRIO_BIT])
        || (|(periph_req & ~periph_prio_ff)));
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_high_ff <= 1'b0;
      irq_low_ff  <= 1'b0;
    end else begin
      irq_high_ff <= nxt_irq_high;
      irq_low_ff  <= nxt_irq_low;
    end
  end

  // Read port; unmapped offsets read zero
  always_comb begin
    case (bus_req.addr)
      eif_pkg::OFS_EXT_CTRL: nxt_rd_data = ext_line_irq_ctrl_ff;
      eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE:     nxt_rd_data = periph_irq_flags_one_ff;
      eif_pkg::OFS_GLOBAL:   nxt_rd_data = global_ctrl_ff;
      eif_pkg::OFS_PIE:      nxt_rd_data = periph_enable_ff;
      eif_pkg::OFS_PIP:      nxt_rd_data = periph_prio_ff;
      default:               nxt_rd_data = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data_ff <= 8'h00;
    end else if (bus_req.rd) begin
      rd_data_ff <= nxt_rd_data;
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  assign rd_data  = rd_data_ff;
  assign irq_high = irq_high_ff;
  assign irq_low  = irq_low_ff;

endmodule

`default_nettype wire

// file: eif_pkg.sv
// Purpose: Shared constants and types for the external-line and peripheral flag block
// Assumes: core_clk is the instruction clock of the core, 100 MHz
// Notes:   Offsets are byte indices on the plain register port
`default_nettype none

package eif_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFS_EXT_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIPH_IRQ_FLAGS_ONE     = 8'h01;
  localparam logic [7:0] OFS_GLOBAL   = 8'h02;
  localparam logic [7:0] OFS_PIE      = 8'h03;
  localparam logic [7:0] OFS_PIP      = 8'h04;

  // ext_line_irq_ctrl fields
  localparam int EXT_TWO_PRIO_BIT = 7;
  localparam int EXT_ONE_PRIO_BIT = 6;
  localparam int EXT_TWO_EN_BIT   = 4;
  localparam int EXT_ONE_EN_BIT   = 3;
  localparam int EXT_TWO_FLAG_BIT = 1;
  localparam int EXT_ONE_FLAG_BIT = 0;
  localparam logic [7:0] EXT_CTRL_RST   = 8'hC0;
  localparam logic [7:0] EXT_CTRL_WMASK = 8'hDB;

  // periph_irq_flags_one fields
  localparam int PSP_BIT  = 7;
  localparam int ADC_BIT  = 6;
  localparam int RX_BIT   = 5;
  localparam int TX_BIT   = 4;
  localparam int SSP_BIT  = 3;
  localparam int CCP_BIT  = 2;
  localparam int TIMER_TWO_COUNT_BIT = 1;
  localparam int TIMER_ONE_COUNT_BIT = 0;
  localparam logic [7:0] PERIPH_IRQ_FLAGS_ONE_RST     = 8'h00;
  localparam logic [7:0] PERIPH_IRQ_FLAGS_ONE_RO_MASK = 8'h30;

  // Global control fields
  localparam int GIE_BIT  = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int PRIORITY_LEVELS_ON_BIT = 0;
  localparam logic [7:0] GLOBAL_RST   = 8'h00;
  localparam logic [7:0] GLOBAL_WMASK = 8'hC1;

  localparam logic [7:0] PIE_RST = 8'h00;
  localparam logic [7:0] PIP_RST = 8'h00;

  // Pin edge to request latency, in instruction cycles
  localparam int INSTR_CLKS   = 1;
  localparam int EXT_LAT_INSTR = 3;
  localparam int EXT_PIPE_LEN = EXT_LAT_INSTR * INSTR_CLKS - 1;

  typedef enum logic [1:0] {
    CCP_OFF     = 2'b00,
    CCP_CAPTURE = 2'b01,
    CCP_COMPARE = 2'b10,
    CCP_PWM     = 2'b11
  } eif_ccp_mode_t;

  typedef struct packed {
    logic psp_access_done;
    logic conv_done;
    logic rx_full;
    logic tx_empty;
    logic ssp_xfer_done;
    logic capture_evt;
    logic compare_evt;
    logic timer_one_overflow;
  } eif_periph_evt_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } eif_bus_req_t;

endpackage

`default_nettype wire

// file: eif_props.sv
// Purpose: Port checker for eif_irq
// Assumes: Shadows follow bus writes and core vector/return pulses
// Notes:   Flags are judged by the bench, not shadowed here
`default_nettype none
module eif_props (
  input wire logic                       core_clk,
  input wire logic                       rst,
  input wire eif_pkg::eif_bus_req_t      bus_req,
  input wire logic [eif_pkg::DATA_W-1:0] rd_data,
  input wire logic                       small_package,
  input wire logic                       ext_line_two,
  input wire eif_pkg::eif_periph_evt_t   periph_evt,
  input wire logic                       vector_taken,
  input wire logic                       vector_high,
  input wire logic                       return_from_irq_instr,
  input wire logic                       return_high,
  input wire logic                       irq_high,
  input wire logic                       irq_low
);
  logic [7:0] glob_ff;
  logic [7:0] ext_ff;
  logic [7:0] pie_ff;
  logic       any_en;
  logic       ext_en;
  assign ext_en = ext_ff[4] | ext_ff[3];
  assign any_en = ext_en | (|pie_ff);
  // Return wins over vector, as the core does
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      glob_ff <= 8'h00;
    end else if (return_from_irq_instr) begin
      glob_ff[(return_high || !glob_ff[0]) ? 7 : 6] <= 1'b1;
    end else if (vector_taken) begin
      glob_ff[(vector_high || !glob_ff[0]) ? 7 : 6] <= 1'b0;
    end else if (bus_req.wr && bus_req.addr == eif_pkg::OFS_GLOBAL) begin
      glob_ff <= bus_req.wdata & eif_pkg::GLOBAL_WMASK;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_ff <= eif_pkg::EXT_CTRL_RST;
      pie_ff <= eif_pkg::PIE_RST;
    end else if (bus_req.wr) begin
      if (bus_req.addr == eif_pkg::OFS_EXT_CTRL) ext_ff <= bus_req.wdata;
      if (bus_req.addr == eif_pkg::OFS_PIE) pie_ff <= bus_req.wdata;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence pir_read;
    bus_req.rd && bus_req.addr == eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE;
  endsequence
  sequence two_rise;
    !ext_line_two ##1 ext_line_two;
  endsequence
  a_read_idle_zero: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
    else $error("read data not zero outside read cycle");
  a_psp_small_zero: assert property (pir_read ##1
    (small_package && $past(small_package, 3)) |-> rd_data[eif_pkg::PSP_BIT] == 1'b0)
    else $error("parallel flag seen on small package");
  a_rx_flag_mirror: assert property (pir_read ##1
    ($past(periph_evt.rx_full) == $past(periph_evt.rx_full, 2))
    |-> rd_data[eif_pkg::RX_BIT] == $past(periph_evt.rx_full)) else $error("rx flag wrong");
  a_tx_flag_mirror: assert property (pir_read ##1
    ($past(periph_evt.tx_empty) == $past(periph_evt.tx_empty, 2))
    |-> rd_data[eif_pkg::TX_BIT] == $past(periph_evt.tx_empty)) else $error("tx flag wrong");
  a_high_global_gate: assert property (irq_high |-> $past(glob_ff[7]))
    else $error("high request without global enable");
  a_low_global_gate: assert property (irq_low
    |-> $past(glob_ff[6]) && $past(glob_ff[0])) else $error("low request without low enable");
  a_request_needs_enable: assert property ((irq_high || irq_low) |-> $past(any_en))
    else $error("request with all enables off");
  a_periph_needs_peripheral_irq_enable: assert property (irq_high && !$past(glob_ff[0])
    && !$past(ext_en) |-> $past(glob_ff[6]))
    else $error("peripheral request without peripheral enable");
  a_pin_latency: assert property (two_rise ##0 (ext_ff[4] && glob_ff[7] && !glob_ff[0])
    |-> ##[3:4] irq_high) else $error("pin request late");
endmodule
bind eif_irq eif_props eif_props_i (.core_clk(core_clk), .rst(rst), .bus_req(bus_req),
  .rd_data(rd_data), .small_package(small_package), .ext_line_two(ext_line_two),
  .periph_evt(periph_evt), .vector_taken(vector_taken), .vector_high(vector_high),
  .return_from_irq_instr(return_from_irq_instr), .return_high(return_high),
  .irq_high(irq_high), .irq_low(irq_low));
`default_nettype wire

// file: eif_core_model.sv
// Purpose: Core side model: vectors on a request, returns after service
// Assumes: Vectors only while serve is high; a service once started runs on to its return
// Notes:   Busy blocks a second vector while the request still stands
`default_nettype none
module eif_core_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       serve,
  input  wire logic [7:0] svc_len,
  input  wire logic       irq_high,
  input  wire logic       irq_low,
  output logic            vector_taken,
  output logic            vector_high,
  output logic            return_from_irq_instr,
  output logic            return_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_ff;
  logic       busy_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
      left_ff <= 8'h00;
      vector_taken <= 1'b0;
      vector_high <= 1'b0;
      return_from_irq_instr <= 1'b0;
      return_high <= 1'b0;
    end else begin
      vector_taken <= 1'b0;
      return_from_irq_instr <= 1'b0;
      if (!busy_ff && serve && (irq_high || irq_low)) begin
        vector_taken <= 1'b1;
        vector_high <= irq_high;
        return_high <= irq_high;
        busy_ff <= 1'b1;
        left_ff <= svc_len;
      end else if (busy_ff && left_ff != 8'h00) begin
        left_ff <= left_ff - 8'h01;
      end else if (busy_ff) begin
        return_from_irq_instr <= 1'b1;
        busy_ff <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: eif_irq_test.sv
// Purpose: Self-checking bench for eif_irq
// Assumes: Flags are judged through register reads
// Notes:   Core model vectors only when serve is raised
`default_nettype none
module eif_irq_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     core_clk = 1'b0;
  logic                     rst = 1'b1;
  eif_pkg::eif_bus_req_t    bus_req = '0;
  eif_pkg::eif_periph_evt_t periph_evt = '0;
  eif_pkg::eif_ccp_mode_t   capcomp_mode = eif_pkg::CCP_CAPTURE;
  logic                     small_package = 1'b0;
  logic                     ext_one = 1'b0;
  logic                     ext_two = 1'b0;
  logic [7:0]               t2_count = 8'h00;
  logic [7:0]               t2_period = 8'h80;
  logic                     serve = 1'b0;
  logic [7:0]               rd_data;
  logic                     vec, vec_hi, ret, ret_hi, irq_high, irq_low;
  int                       miscompares = 0;
  int                       check_count = 0;
  int                       cycles = 0;
  eif_irq eif_irq_i (.core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
    .small_package(small_package), .ext_line_one(ext_one), .ext_line_two(ext_two),
    .periph_evt(periph_evt), .capcomp_mode(capcomp_mode), .timer_two_count(t2_count),
    .timer_two_period(t2_period), .vector_taken(vec), .vector_high(vec_hi),
    .return_from_irq_instr(ret), .return_high(ret_hi), .irq_high(irq_high), .irq_low(irq_low));
  eif_core_model eif_core_model_i (.core_clk(core_clk), .rst(rst), .serve(serve),
    .svc_len(8'h08), .irq_high(irq_high), .irq_low(irq_low), .vector_taken(vec),
    .vector_high(vec_hi), .return_from_irq_instr(ret), .return_high(ret_hi));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test;
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 chk(rd_data, e);
    @(posedge core_clk);
  endtask
  task automatic irq_chk(input logic [7:0] e);
    #1 chk({6'h00, irq_high, irq_low}, e);
    @(posedge core_clk);
  endtask
  task automatic pulse(input logic [7:0] v);
    periph_evt <= periph_evt | v;
    @(posedge core_clk);
    periph_evt <= periph_evt & ~v;
    @(posedge core_clk);
  endtask
  task automatic t_reset;
    rd_chk(eif_pkg::OFS_EXT_CTRL, eif_pkg::EXT_CTRL_RST);
    rd_chk(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, eif_pkg::PERIPH_IRQ_FLAGS_ONE_RST);
    rd_chk(eif_pkg::OFS_GLOBAL, 8'h00);
    rd_chk(eif_pkg::OFS_PIE, 8'h00);
    rd_chk(eif_pkg::OFS_PIP, 8'h00);
    rd_chk(8'h07, 8'h00);
  endtask
  task automatic t_poll;
    ext_one <= 1'b1;
    ext_two <= 1'b1;
    cyc(6);
    rd_chk(eif_pkg::OFS_EXT_CTRL, 8'hC3);
    irq_chk(8'h00);
    wr(eif_pkg::OFS_EXT_CTRL, 8'hFF);
    rd_chk(eif_pkg::OFS_EXT_CTRL, 8'hDB);
    ext_one <= 1'b0;
    ext_two <= 1'b0;
    wr(eif_pkg::OFS_EXT_CTRL, 8'hC0);
    rd_chk(eif_pkg::OFS_EXT_CTRL, 8'hC0);
  endtask
  task automatic t_periph;
    logic [7:0] e;
    for (int j = 0; j < 8; j++) begin
      if (j == 4 || j == 5) continue;
      capcomp_mode <= (j == 1) ? eif_pkg::CCP_COMPARE : eif_pkg::CCP_CAPTURE;
      pulse(8'(1 << j));
      cyc(4);
      e = (j == 1) ? 8'h04 : 8'(1 << j);
      rd_chk(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, e);
      wr(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, 8'h00);
      rd_chk(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, 8'h00);
    end
    capcomp_mode <= eif_pkg::CCP_PWM;
    pulse(8'h06);
    cyc(4);
    rd_chk(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, 8'h00);
    t2_period <= 8'h5A;
    t2_count <= 8'h5A;
    @(posedge core_clk);
    t2_count <= 8'h5B;
    cyc(3);
    rd_chk(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, 8'h02);
    wr(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, 8'h00);
  endtask
  task automatic t_small;
    small_package <= 1'b1;
    pulse(8'h80);
    rd_chk(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, 8'h00);
    wr(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, 8'h80);
    rd_chk(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, 8'h00);
    wr(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, 8'h00);
    small_package <= 1'b0;
  endtask
  task automatic t_ro;
    periph_evt.rx_full <= 1'b1;
    periph_evt.tx_empty <= 1'b1;
    cyc(2);
    wr(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, 8'h00);
    rd_chk(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, 8'h30);
    periph_evt.rx_full <= 1'b0;
    cyc(2);
    rd_chk(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, 8'h10);
    periph_evt.tx_empty <= 1'b0;
    cyc(2);
    rd_chk(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, 8'h00);
  endtask
  task automatic t_irq;
    int n;
    wr(eif_pkg::OFS_GLOBAL, 8'h80);
    wr(eif_pkg::OFS_EXT_CTRL, 8'hD0);
    ext_two <= 1'b1;
    for (n = 0; irq_high !== 1'b1 && n < 9; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk(8'(n >= 3 && n <= 4), 8'h01);
    @(posedge core_clk);
    serve <= 1'b1;
    cyc(4);
    irq_chk(8'h00);
    serve <= 1'b0;
    wr(eif_pkg::OFS_EXT_CTRL, 8'hC0);
    cyc(12);
    rd_chk(eif_pkg::OFS_GLOBAL, 8'h80);
    ext_two <= 1'b0;
    wr(eif_pkg::OFS_PIE, 8'h40);
    pulse(8'h40);
    cyc(2);
    irq_chk(8'h00);
    wr(eif_pkg::OFS_GLOBAL, 8'hC0);
    cyc(1);
    irq_chk(8'h02);
    wr(eif_pkg::OFS_PERIPH_IRQ_FLAGS_ONE, 8'h00);
    wr(eif_pkg::OFS_PIE, 8'h00);
  endtask
  task automatic t_prio;
    wr(eif_pkg::OFS_EXT_CTRL, 8'h58);
    wr(eif_pkg::OFS_GLOBAL, 8'hC1);
    ext_two <= 1'b1;
    cyc(6);
    irq_chk(8'h01);
    ext_one <= 1'b1;
    cyc(6);
    irq_chk(8'h03);
    wr(eif_pkg::OFS_GLOBAL, 8'h41);
    cyc(1);
    irq_chk(8'h01);
    wr(eif_pkg::OFS_EXT_CTRL, 8'h58);
    cyc(1);
    irq_chk(8'h00);
    wr(eif_pkg::OFS_PIP, 8'h40);
    wr(eif_pkg::OFS_PIE, 8'h40);
    pulse(8'h40);
    cyc(1);
    irq_chk(8'h00);
    wr(eif_pkg::OFS_GLOBAL, 8'hC1);
    cyc(1);
    irq_chk(8'h02);
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_poll();
    t_periph();
    t_small();
    t_ro();
    t_irq();
    t_prio();
    stop_test();
  end
endmodule
`default_nettype wire
